// ---- ccl_lock_fault.sv ----
// Current-limit lock fault response with a Wishbone classic register slave.
// Assumes an external comparator flags current above the threshold code,
// and the PWM logic gives one pulse per PWM period and per limiter trip.
`timescale 1ns/1ps
// Behaviour
// - Lock response mode is a 4-bit read/write field at bits 18..15.
// - Mode 0h: latch fault, assert fault indicator, all half-bridges high impedance.
// - Mode 1h: latch fault, assert fault indicator, output stage recirculates.
// - Mode 2h: latch, indicate, all high sides on; 3h: all low sides on.
// - Modes 4h..7h: hold tristate/recirculate/high/low brake, recover after retry time.
// - Mode 8h: report lock as status only; stage unchanged, nothing latched.
// - Modes 9h..Fh: lock detection disabled, no report and no action.
// - Bits 14..11 pick filter time 1 ms up to 50 s.
// - Bits 10..8 plus one give PWM cycles the pulse limiter waits before retrying.
// - A 3-bit code picks retry time from 100 ms to 10000 ms.
// - Lock threshold is 0.1 V per code on the sense amplifier output.
module ccl_lock_fault
  import ccl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Lock sensing
  input wire logic over_thr_i,
  output logic [3:0] lock_thr_code_o,
  // Pulse-by-pulse limiter
  input wire logic pwm_cycle_i,
  input wire logic limit_trip_i,
  output logic limit_hold_o,
  // Fault line and output stage
  output logic fault_indicator_n_o,
  output ccl_stage_t stage_o
);

  // Register state
  logic [31:0] cfg;
  logic report_flag;
  ccl_state_t state;
  ccl_state_t next_state;
  ccl_stage_t next_stage;
  ccl_stage_t held_stage;
  logic [2:0] cbc_left;

  // Field decode
  ccl_cfg_t f;
  assign f.thr = cfg[THR_LSB +: 4];
  assign f.mode = cfg[MODE_LSB +: 4];
  assign f.deg = cfg[DEG_LSB +: 4];
  assign f.cbc = cfg[CBC_LSB +: 3];
  assign f.retry = cfg[RETRY_LSB +: 3];

  // Mode classes
  wire mode_latch = (f.mode < MODE_AUTO_MIN);
  wire mode_auto = (f.mode >= MODE_AUTO_MIN) && (f.mode < MODE_REPORT);
  wire mode_report = (f.mode == MODE_REPORT);
  wire detect_en = (f.mode < MODE_DIS_MIN);

  // Stage action chosen by the low two mode bits
  ccl_stage_t mode_stage;
  always_comb begin
    case (f.mode[1:0])
      2'h0: mode_stage = STAGE_HIZ;
      2'h1: mode_stage = STAGE_RECIRC;
      2'h2: mode_stage = STAGE_HS;
      2'h3: mode_stage = STAGE_LS;
      default: mode_stage = STAGE_HIZ;
    endcase
  end

  // Bus decode
  wire bus_req = cyc_i & stb_i;
  wire bus_take = bus_req & ~ack_o;
  wire bus_wr = bus_req & ack_o & we_i;
  wire hit_cfg = (adr_i == CFG_ADDR);
  wire hit_stat = (adr_i == STAT_ADDR);

  logic [31:0] sel_mask;
  assign sel_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] wr_mask = sel_mask & CFG_WMASK;
  wire [31:0] next_cfg = (cfg & ~wr_mask) | (dat_i & wr_mask);

  // Status write-one-to-clear strobes
  wire stat_wr = bus_wr & hit_stat & sel_i[0];
  wire clr_report = stat_wr & dat_i[ST_REPORT_BIT];
  wire clr_latch = stat_wr & dat_i[ST_LATCH_BIT];

  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[ST_REPORT_BIT] = report_flag;
    status[ST_LATCH_BIT] = (state == ST_LATCH);
    status[ST_RETRY_BIT] = (state == ST_RETRY);
    status[ST_CBC_BIT] = limit_hold_o;
  end

  wire [31:0] rd_data = hit_cfg ? (cfg & CFG_WMASK) :
                        hit_stat ? status : 32'h0000_0000;

  // Deglitch filter: restarts whenever the excursion breaks
  wire deg_run = over_thr_i & detect_en & (state == ST_MON);
  wire deg_tick;
  wire deg_done;

  ccl_ms_tick #(
    .CYC(TICK_CYCLES)
  ) u_deg_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(~deg_run),
    .tick_o(deg_tick)
  );

  ccl_ms_count u_deg_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(~deg_run),
    .tick_i(deg_tick),
    .limit_i(DEG_MS[f.deg]),
    .done_o(deg_done)
  );

  wire lock_evt = deg_run & deg_done;

  // Recovery delay for the automatic modes
  wire retry_run = (state == ST_RETRY);
  wire retry_tick;
  wire retry_done;

  ccl_ms_tick #(
    .CYC(TICK_CYCLES)
  ) u_retry_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(~retry_run),
    .tick_o(retry_tick)
  );

  ccl_ms_count u_retry_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(~retry_run),
    .tick_i(retry_tick),
    .limit_i(RETRY_MS[f.retry]),
    .done_o(retry_done)
  );

  // Fault response sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_MON: begin
        if (lock_evt) begin
          if (mode_latch) begin
            next_state = ST_LATCH;
          end else if (mode_auto) begin
            next_state = ST_RETRY;
          end else if (mode_report) begin
            next_state = ST_REPORT;
          end else begin
            next_state = ST_MON;
          end
        end
      end
      ST_LATCH: begin
        if (clr_latch) begin
          next_state = ST_MON;
        end
      end
      ST_RETRY: begin
        if (retry_done) begin
          next_state = ST_MON;
        end
      end
      ST_REPORT: begin
        // Wait for the excursion to end before watching again
        if (!over_thr_i || !detect_en) begin
          next_state = ST_MON;
        end
      end
      default: next_state = ST_MON;
    endcase
  end

  // Stage command: captured on entry so a config change cannot swap it
  wire fault_entry = (state == ST_MON);
  ccl_stage_t entry_stage;
  assign entry_stage = fault_entry ? mode_stage : held_stage;

  always_comb begin
    case (next_state)
      ST_LATCH: begin
        next_stage = entry_stage;
      end
      ST_RETRY: begin
        next_stage = entry_stage;
      end
      ST_REPORT: begin
        next_stage = STAGE_RUN;
      end
      ST_MON: begin
        next_stage = STAGE_RUN;
      end
      default: begin
        next_stage = STAGE_RUN;
      end
    endcase
  end

  // Fault line low while latched and while waiting to retry
  logic next_fault_n;
  always_comb begin
    case (next_state)
      ST_LATCH: next_fault_n = 1'b0;
      ST_RETRY: next_fault_n = 1'b0;
      default: next_fault_n = 1'b1;
    endcase
  end

  // Sticky report flag, a new lock wins over a clear
  wire report_set = lock_evt & mode_report;

  // Pulse-by-pulse limiter hold-off in PWM periods
  wire cbc_release = limit_hold_o & pwm_cycle_i & (cbc_left == 3'h0);
  logic next_limit_hold;
  logic [2:0] next_cbc_left;

  // A new trip reloads the count even while holding
  always_comb begin
    next_limit_hold = limit_hold_o;
    next_cbc_left = cbc_left;
    if (limit_trip_i) begin
      next_limit_hold = 1'b1;
      next_cbc_left = f.cbc;
    end else if (cbc_release) begin
      next_limit_hold = 1'b0;
    end else if (limit_hold_o && pwm_cycle_i) begin
      next_cbc_left = cbc_left - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_hold_o <= 1'b0;
      cbc_left <= 3'h0;
    end else begin
      limit_hold_o <= next_limit_hold;
      cbc_left <= next_cbc_left;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_MON;
      held_stage <= STAGE_RUN;
      stage_o <= STAGE_RUN;
      fault_indicator_n_o <= 1'b1;
    end else begin
      state <= next_state;
      held_stage <= next_stage;
      stage_o <= next_stage;
      fault_indicator_n_o <= next_fault_n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      report_flag <= 1'b0;
    end else if (report_set) begin
      report_flag <= 1'b1;
    end else if (clr_report) begin
      report_flag <= 1'b0;
    end
  end

  // Threshold code to the comparator: 0.1 V per step of sense output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_thr_code_o <= 4'h0;
    end else begin
      lock_thr_code_o <= f.thr;
    end
  end

  // Configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= CFG_RESET;
    end else if (bus_wr && hit_cfg) begin
      cfg <= next_cfg;
    end
  end

  // Bus answer: ack one cycle after the request, write at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_take;
      if (bus_take && !we_i) begin
        dat_o <= rd_data;
      end
    end
  end

endmodule

// ---- ccl_pkg.sv ----
// Constants, register map and types for the current-lock fault response block.
// Assumes a 40 MHz system clock; register offsets are Wishbone byte addresses.
package ccl_pkg;

  // Timing base: the timers count 1 ms ticks
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYC = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map, byte address = index * 4
  localparam logic [11:0] CFG_INDEX = 12'h092;
  localparam logic [11:0] CFG_ADDR = {CFG_INDEX[9:0], 2'b00};
  localparam logic [11:0] STAT_INDEX = 12'h0a0;
  localparam logic [11:0] STAT_ADDR = {STAT_INDEX[9:0], 2'b00};

  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // Bits 30 and 7 are reserved and read as zero
  localparam logic [31:0] CFG_WMASK = 32'hbfff_ff7f;

  // Field positions in the configuration register
  localparam int THR_LSB = 19;
  localparam int MODE_LSB = 15;
  localparam int DEG_LSB = 11;
  localparam int CBC_LSB = 8;
  localparam int RETRY_LSB = 0;

  // Mode decoding
  localparam logic [3:0] MODE_AUTO_MIN = 4'h4;
  localparam logic [3:0] MODE_REPORT = 4'h8;
  localparam logic [3:0] MODE_DIS_MIN = 4'h9;

  // Status register bits
  localparam int ST_REPORT_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_RETRY_BIT = 2;
  localparam int ST_CBC_BIT = 3;

  // Filter times in ms for codes 0h..Fh
  localparam logic [15:0] DEG_MS [16] = '{
    16'h0001, 16'h0002, 16'h0005, 16'h000a, 16'h0019, 16'h0032, 16'h004b, 16'h0064,
    16'h00fa, 16'h01f4, 16'h03e8, 16'h09c4, 16'h1388, 16'h2710, 16'h61a8, 16'hc350};

  // Recovery delays in ms for codes 0h..7h
  localparam logic [15:0] RETRY_MS [8] = '{
    16'h0064, 16'h01f4, 16'h03e8, 16'h07d0, 16'h0bb8, 16'h1388, 16'h1d4c, 16'h2710};

  // Output stage command; all zero means normal drive
  typedef struct packed {
    logic hiz;
    logic recirc;
    logic hs_on;
    logic ls_on;
  } ccl_stage_t;

  localparam ccl_stage_t STAGE_RUN = 4'h0;
  localparam ccl_stage_t STAGE_HIZ = 4'h8;
  localparam ccl_stage_t STAGE_RECIRC = 4'h4;
  localparam ccl_stage_t STAGE_HS = 4'h2;
  localparam ccl_stage_t STAGE_LS = 4'h1;

  // Decoded configuration fields
  typedef struct packed {
    logic [3:0] thr;
    logic [3:0] mode;
    logic [3:0] deg;
    logic [2:0] cbc;
    logic [2:0] retry;
  } ccl_cfg_t;

  typedef enum logic [1:0] {
    ST_MON,
    ST_LATCH,
    ST_RETRY,
    ST_REPORT
  } ccl_state_t;

endpackage

// ---- ccl_ms_tick.sv ----
// Millisecond tick prescaler with a restart input.
// Assumes clear_i is synchronous; the tick is one clock wide.
`timescale 1ns/1ps
module ccl_ms_tick #(
  parameter int CYC = 40000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  output logic tick_o
);
  localparam int W = $clog2(CYC + 1);

  logic [W-1:0] cnt;
  wire wrap = (cnt == W'(CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  assign tick_o = wrap & ~clear_i;
endmodule

// ---- ccl_ms_count.sv ----
// Saturating millisecond counter with a limit compare.
// Assumes tick_i comes from a prescaler cleared together with this counter.
`timescale 1ns/1ps
module ccl_ms_count (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [15:0] limit_i,
  output logic done_o
);
  logic [15:0] cnt;

  assign done_o = (cnt >= limit_i);

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt <= 16'h0000;
    end else if (tick_i && !done_o) begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// ---- ccl_monitor.sv ----
// Port checker for the current-lock fault response block.
// Assumes it is bound to ccl_lock_fault with TICK_CYCLES of 4 or more.
`timescale 1ns/1ps
module ccl_monitor
  import ccl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic over_thr_i,
  input wire logic pwm_cycle_i,
  input wire logic limit_trip_i,
  input wire logic limit_hold_o,
  input wire logic fault_indicator_n_o,
  input wire ccl_stage_t stage_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_trip_hold: assert property (limit_trip_i |=> limit_hold_o)
    else $error("limiter trip not held");
  a_hold_release: assert property ($fell(limit_hold_o) |-> $past(pwm_cycle_i))
    else $error("limiter released off a pwm pulse");
  a_stage_onehot: assert property ($onehot0(stage_o))
    else $error("conflicting stage commands");
  a_fault_stage: assert property (!fault_indicator_n_o |-> stage_o != STAGE_RUN)
    else $error("fault shown with normal drive");
  a_run_stage: assert property (fault_indicator_n_o |-> stage_o == STAGE_RUN)
    else $error("stage changed without fault");
  a_lock_filter: assert property ($fell(fault_indicator_n_o) |-> $past(over_thr_i, 1) && $past(over_thr_i, 4))
    else $error("fault before filter time");
  c_fault: cover property ($fell(fault_indicator_n_o));
  c_recover: cover property ($rose(fault_indicator_n_o));
  c_release: cover property ($fell(limit_hold_o));
endmodule

// ---- ccl_stage_model.sv ----
// Power stage, current comparator and PWM period source.
// Assumes the stage command and threshold code come from the block.
`timescale 1ns/1ps
module ccl_stage_model
  import ccl_pkg::*;
#(
  parameter int PWM_PER = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] level_i,
  input wire logic [3:0] thr_i,
  input wire ccl_stage_t stage_i,
  output logic over_o,
  output logic pwm_o
);
  logic [7:0] cnt;
  // Current collapses once the stage stops driving
  assign over_o = (level_i > thr_i) && (stage_i == STAGE_RUN);
  assign pwm_o = (cnt == 8'h00) && !rst_i;
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt == 8'(PWM_PER - 1)) cnt <= 8'h00;
    else cnt <= cnt + 8'h01;
  end
endmodule

// ---- ccl_lock_fault_tb.sv ----
// Self-checking bench for the current-lock fault response block.
// Assumes a 1 ms tick of 4 clocks and a threshold code of 5.
`timescale 1ns/1ps
module ccl_lock_fault_tb;
  import ccl_pkg::*;
  localparam int TK = 4;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, limit_trip_i = 0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'hf, level = 4'h0, lock_thr_code_o;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, over_thr_i, pwm_cycle_i, limit_hold_o, fault_indicator_n_o;
  ccl_stage_t stage_o;
  int num_errors = 0, checks = 0;
  always #12.5 clk_i = ~clk_i;
  ccl_lock_fault #(.TICK_CYCLES(TK)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .over_thr_i(over_thr_i), .lock_thr_code_o(lock_thr_code_o), .pwm_cycle_i(pwm_cycle_i),
    .limit_trip_i(limit_trip_i), .limit_hold_o(limit_hold_o),
    .fault_indicator_n_o(fault_indicator_n_o), .stage_o(stage_o));
  ccl_stage_model u_stage (.clk_i(clk_i), .rst_i(rst_i), .level_i(level), .thr_i(lock_thr_code_o),
    .stage_i(stage_o), .over_o(over_thr_i), .pwm_o(pwm_cycle_i));
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    q = dat_o;
    cyc_i <= 0; stb_i <= 0;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function logic [31:0] cfgw(input logic [3:0] m, input logic [3:0] d, input logic [2:0] c);
    return {9'h000, 4'h5, m, d, c, 5'h00, 3'h0};
  endfunction
  function ccl_stage_t exp_stage(input logic [3:0] m);
    case (m[1:0])
      2'h0: return STAGE_HIZ;
      2'h1: return STAGE_RECIRC;
      2'h2: return STAGE_HS;
      default: return STAGE_LS;
    endcase
  endfunction
  initial begin
    #(25 * 20000);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    summarize();
  end
  initial begin
    logic [3:0] m, d;
    int cnt, t;
    void'($urandom(42269));
    idle(6);
    rst_i <= 0;
    wb(0, CFG_ADDR, 32'h0, rd);
    chk(rd, CFG_RESET, "cfg reset");
    wb(1, CFG_ADDR, 32'hffffffff, rd);
    wb(0, CFG_ADDR, 32'h0, rd);
    chk(rd, CFG_WMASK, "cfg rw");
    wb(0, 12'hffc, 32'h0, rd);
    chk(rd, 32'h0, "unmapped");
    $display("test regs done");
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      d = 4'($urandom % 2);
      wb(1, CFG_ADDR, cfgw(m, d, 3'h0), rd);
      level <= 4'h9;
      idle(int'(DEG_MS[d]) * TK - 1);
      level <= 4'($urandom % 6);
      idle(3);
      chk(fault_indicator_n_o, 1, "glitch");
      level <= 4'h9;
      idle(int'(DEG_MS[d]) * TK + 4);
      if (m < 4'h8) begin
        chk(fault_indicator_n_o, 0, "fault");
        chk(stage_o, exp_stage(m), "stage");
        chk(lock_thr_code_o, 4'h5, "threshold code");
      end else begin
        chk(fault_indicator_n_o, 1, "no fault");
        chk(stage_o, STAGE_RUN, "stage kept");
      end
      level <= 4'h2;
      if (m >= 4'h4 && m < 4'h8) begin
        idle(int'(RETRY_MS[0]) * TK - 8);
        chk(fault_indicator_n_o, 0, "retry hold");
        wb(0, STAT_ADDR, 32'h0, rd);
        chk(rd[2], 1, "retry status");
        idle(12);
        chk({fault_indicator_n_o, stage_o}, 5'h10, "recovered");
      end else if (m < 4'h4) begin
        idle(20);
        chk(fault_indicator_n_o, 0, "latched");
        wb(0, STAT_ADDR, 32'h0, rd);
        chk(rd[1], 1, "latch status");
        wb(1, STAT_ADDR, 32'h3, rd);
        idle(2);
        chk(fault_indicator_n_o, 1, "cleared");
      end else begin
        wb(0, STAT_ADDR, 32'h0, rd);
        chk(rd[0], m == 4'h8, "report");
        wb(1, STAT_ADDR, 32'h1, rd);
      end
      $display("test mode %0h done", m);
    end
    for (int k = 0; k < 8; k++) begin
      wb(1, CFG_ADDR, cfgw(4'h9, 4'h0, 3'(k)), rd);
      idle($urandom % 8);
      limit_trip_i <= 1;
      @(posedge clk_i);
      limit_trip_i <= 0;
      cnt = 0;
      t = 0;
      do begin
        @(negedge clk_i);
        if (pwm_cycle_i && limit_hold_o) cnt++;
        t++;
      end while (limit_hold_o !== 1'b0 && t < 200);
      chk(cnt, k + 1, "retry count");
    end
    $display("test limiter done");
    summarize();
  end
endmodule
bind ccl_lock_fault ccl_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .over_thr_i(over_thr_i), .pwm_cycle_i(pwm_cycle_i), .limit_trip_i(limit_trip_i),
  .limit_hold_o(limit_hold_o), .fault_indicator_n_o(fault_indicator_n_o), .stage_o(stage_o));
